// File: pkg/exen_pkg.sv
package exen_pkg;
	localparam logic [11:0] OFF_SCRATCH = 12'h000;
	localparam logic [11:0] OFF_CAUSE = 12'h004;
	localparam logic [11:0] OFF_FAULT_ADDR = 12'h008;
	localparam logic [11:0] OFF_RET_ADDR = 12'h00c;
	localparam logic [11:0] OFF_SAVED_STATUS = 12'h010;
	localparam logic [11:0] OFF_SAVED_TARGET = 12'h014;
	localparam logic [11:0] OFF_LIVE_STATUS = 12'h018;
	localparam logic [11:0] OFF_VEC_BASE = 12'h01c;
	localparam logic [11:0] OFF_EXT_PERMIT = 12'h020;
	localparam logic [31:0] RST_SCRATCH = 32'h00000000;
	localparam logic [31:0] RST_STATUS = 32'h00000000;
	localparam logic [31:0] RST_VEC_BASE = 32'h00000000;
	localparam logic [31:0] RST_EXT_PERMIT = 32'hffffffff;
	localparam int ST_USER = 7;
	localparam int ST_EXC_ACTIVE = 5;
	localparam int ST_PENDING_SLOT = 6;
	localparam int ST_LVL2_ACTIVE = 3;
	localparam int ST_LVL1_ACTIVE = 2;
	localparam int ST_LVL2_EN = 1;
	localparam int ST_LVL1_EN = 0;
	localparam logic [7:0] VEC_MACHINE_CHECK = 8'h20;
	localparam logic [7:0] VEC_INSN_ERROR = 8'h02;
	localparam logic [7:0] VEC_PRIV_VIOL = 8'h24;
	localparam logic [7:0] VEC_TRAP = 8'h25;
	localparam logic [7:0] VEC_DTLB_MISS = 8'h22;
	localparam logic [7:0] VEC_PROT_VIOL = 8'h23;
	localparam logic [7:0] CODE_DOUBLE_FAULT = 8'h00;
	localparam logic [7:0] CODE_ILLEGAL = 8'h00;
	localparam logic [7:0] CODE_PRIV = 8'h00;
	localparam logic [7:0] CODE_DISABLED_EXT = 8'h01;
	localparam int VEC_SHIFT = 3;

	// Fault flags from commit, highest priority first, except that a user-mode return_from_handler ranks above memAccess and trap
	typedef struct packed {
		logic extUnmapped;
		logic extDisabled;
		logic memAccess;
		logic trap;
		logic return_from_handler;
		logic other;
	} exen_fault_t;

	typedef struct packed {
		logic valid;
		logic [31:0] pc;
		logic [31:0] nextPc;
		logic [31:0] memAddr;
		logic [31:0] pendTarget;
		logic inSlot;
		logic [7:0] otherVec;
		logic [7:0] otherCode;
		logic [7:0] param;
		logic [5:0] extGroup;
		exen_fault_t fault;
	} exen_commit_t;

	typedef struct packed {
		logic [31:0] pc;
		logic armBranch;
		logic [31:0] target;
	} exen_redirect_t;
endpackage

// File: hw/exen_entry_exit.sv
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Cancel faulting and younger instructions
// - Cancelled instruction blocks extension writes, except a winning trap
// - Return address is faulting fetch PC
// - Trap returns to architectural next PC
// - Saved status takes last committed status
// - Delay-slot fault sets saved pending flag
// - Pending target copied to saved target
// - Cause code written on entry
// - Fault address: access or instruction
// - Entry clears user and interrupt enables
// - Entry sets exception active flag
// - PC vectors from type and base
// - Live pending flag cleared after saving
// - Entry changes nothing else
// - Scratch word freely readable and writable
// - Return picks saved set; user faults
// - Exception exit when active or idle
// - Interrupt exit uses level 2 first
// - Exit restores PC, status, branch target
// - Restored pending flag arms delayed branch
// - Delay-slot fault returns to slot
// - Disabled extension raises privilege violation
// - Unmapped extension raises illegal instruction
// - Only highest-priority exception taken
// - Fault while active becomes machine check
module exen_entry_exit
	import exen_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire exen_commit_t commit,
	input wire logic [31:0] lvl1LinkAddr,
	input wire logic [31:0] lvl2LinkAddr,
	input wire logic [31:0] lvl1SavedStatus,
	input wire logic [31:0] lvl2SavedStatus,
	input wire logic [31:0] lvl1SavedTarget,
	input wire logic [31:0] lvl2SavedTarget,
	output logic flushPipe,
	output logic blockExtWrite,
	output logic redirectValid,
	output exen_redirect_t redirect,
	output logic [31:0] liveStatus,
	output logic [31:0] branchTarget
);
	typedef struct packed {
		logic [31:0] scratch;
		logic [7:0] causeVec;
		logic [7:0] causeCode;
		logic [7:0] causeParam;
		logic [31:0] faultAddr;
		logic [31:0] retAddr;
		logic [31:0] savedStatus;
		logic [31:0] savedTarget;
		logic [31:0] status;
		logic [31:0] branch_target_reg;
		logic [31:0] vecBase;
		logic [31:0] extPermit;
		logic redirValid;
		exen_redirect_t redir;
		logic [31:0] rdata;
	} exen_state_t;

	exen_state_t s_q, s_d;
	logic rstMeta_q, rstSync_q;
	logic take, isFault, doReturn, extDis, trapWins;
	logic [7:0] vec, code;
	logic [31:0] selPc, selStatus, selTarget;
	logic apbWr, apbRd;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rstMeta_q <= 1'b0;
			rstSync_q <= 1'b0;
		end else begin
			rstMeta_q <= 1'b1;
			rstSync_q <= rstMeta_q;
		end
	end

	assign apbWr = psel && penable && pwrite;
	assign apbRd = psel && !penable && !pwrite;
	assign extDis = commit.fault.extUnmapped ? 1'b0 : !s_q.extPermit[commit.extGroup[4:0]];

	// Return request; a user-mode return is a fault
	assign doReturn = commit.valid && commit.fault.return_from_handler && !s_q.status[ST_USER];
	assign isFault = commit.valid && (commit.fault.extUnmapped || commit.fault.extDisabled ||
		commit.fault.memAccess || commit.fault.trap || commit.fault.other ||
		(commit.fault.return_from_handler && s_q.status[ST_USER]));
	assign take = isFault;
	assign trapWins = commit.fault.trap && !commit.fault.extUnmapped &&
		!commit.fault.extDisabled && !commit.fault.memAccess &&
		!(commit.fault.return_from_handler && s_q.status[ST_USER]) && !s_q.status[ST_EXC_ACTIVE];

	// Priority selection of vector and cause
	always_comb begin
		vec = commit.otherVec;
		code = commit.otherCode;
		if (s_q.status[ST_EXC_ACTIVE]) begin
			vec = VEC_MACHINE_CHECK;
			code = CODE_DOUBLE_FAULT;
		end else if (commit.fault.extUnmapped) begin
			vec = VEC_INSN_ERROR;
			code = CODE_ILLEGAL;
		end else if (commit.fault.extDisabled) begin
			vec = VEC_PRIV_VIOL;
			code = extDis ? CODE_DISABLED_EXT : CODE_PRIV;
		end else if (commit.fault.return_from_handler && s_q.status[ST_USER]) begin
			vec = VEC_PRIV_VIOL;
			code = CODE_PRIV;
		end else if (commit.fault.memAccess) begin
			vec = commit.otherVec;
			code = commit.otherCode;
		end else if (commit.fault.trap) begin
			vec = VEC_TRAP;
			code = 8'h00;
		end
	end

	// Saved set chosen by active flags
	always_comb begin
		selPc = s_q.retAddr;
		selStatus = s_q.savedStatus;
		selTarget = s_q.savedTarget;
		if (!s_q.status[ST_EXC_ACTIVE] && s_q.status[ST_LVL2_ACTIVE]) begin
			selPc = lvl2LinkAddr;
			selStatus = lvl2SavedStatus;
			selTarget = lvl2SavedTarget;
		end else if (!s_q.status[ST_EXC_ACTIVE] && s_q.status[ST_LVL1_ACTIVE]) begin
			selPc = lvl1LinkAddr;
			selStatus = lvl1SavedStatus;
			selTarget = lvl1SavedTarget;
		end
	end

	always_comb begin
		s_d = s_q;
		s_d.redirValid = 1'b0;
		if (apbRd) begin
			case (paddr)
				OFF_SCRATCH: s_d.rdata = s_q.scratch;
				OFF_CAUSE: s_d.rdata = {8'h00, s_q.causeVec, s_q.causeCode, s_q.causeParam};
				OFF_FAULT_ADDR: s_d.rdata = s_q.faultAddr;
				OFF_RET_ADDR: s_d.rdata = s_q.retAddr;
				OFF_SAVED_STATUS: s_d.rdata = s_q.savedStatus;
				OFF_SAVED_TARGET: s_d.rdata = s_q.savedTarget;
				OFF_LIVE_STATUS: s_d.rdata = s_q.status;
				OFF_VEC_BASE: s_d.rdata = s_q.vecBase;
				OFF_EXT_PERMIT: s_d.rdata = s_q.extPermit;
				default: s_d.rdata = 32'h00000000;
			endcase
		end
		if (apbWr) begin
			case (paddr)
				OFF_SCRATCH: s_d.scratch = pwdata;
				OFF_RET_ADDR: s_d.retAddr = pwdata;
				OFF_SAVED_STATUS: s_d.savedStatus = pwdata;
				OFF_SAVED_TARGET: s_d.savedTarget = pwdata;
				OFF_LIVE_STATUS: s_d.status = pwdata;
				OFF_VEC_BASE: s_d.vecBase = pwdata;
				OFF_EXT_PERMIT: s_d.extPermit = pwdata;
				default: ;
			endcase
		end
		if (take) begin
			// Entry: every update lands in this single cycle
			s_d.retAddr = trapWins ? commit.nextPc : commit.pc;
			s_d.savedStatus = s_q.status;
			s_d.savedStatus[ST_PENDING_SLOT] = commit.inSlot;
			if (commit.inSlot) begin
				s_d.savedTarget = commit.pendTarget;
			end
			s_d.causeVec = vec;
			s_d.causeCode = code;
			s_d.causeParam = commit.fault.extDisabled ? {2'b00, commit.extGroup} : commit.param;
			s_d.faultAddr = commit.fault.memAccess ? commit.memAddr : commit.pc;
			s_d.status[ST_USER] = 1'b0;
			s_d.status[ST_LVL1_EN] = 1'b0;
			s_d.status[ST_LVL2_EN] = 1'b0;
			s_d.status[ST_EXC_ACTIVE] = 1'b1;
			s_d.status[ST_PENDING_SLOT] = 1'b0;
			s_d.redirValid = 1'b1;
			s_d.redir.pc = s_q.vecBase + ({24'h000000, vec} << VEC_SHIFT);
			s_d.redir.armBranch = 1'b0;
			s_d.redir.target = s_q.branch_target_reg;
		end else if (doReturn) begin
			s_d.status = selStatus;
			s_d.branch_target_reg = selTarget;
			s_d.redirValid = 1'b1;
			s_d.redir.pc = selPc;
			s_d.redir.armBranch = selStatus[ST_PENDING_SLOT];
			s_d.redir.target = selTarget;
		end else if (commit.valid && commit.inSlot) begin
			s_d.branch_target_reg = commit.pendTarget;
		end
	end

	always_ff @(posedge clk or negedge rstSync_q) begin
		if (!rstSync_q) begin
			s_q <= '0;
			s_q.scratch <= RST_SCRATCH;
			s_q.status <= RST_STATUS;
			s_q.vecBase <= RST_VEC_BASE;
			s_q.extPermit <= RST_EXT_PERMIT;
		end else begin
			s_q <= s_d;
		end
	end

	// Cancel in the detection cycle; only a winning trap still commits its extension write
	assign flushPipe = take;
	assign blockExtWrite = take && !trapWins;
	assign redirectValid = s_q.redirValid;
	assign redirect = s_q.redir;
	assign liveStatus = s_q.status;
	assign branchTarget = s_q.branch_target_reg;
	assign prdata = s_q.rdata;
	assign pready = 1'b1;
	assign pslverr = 1'b0;

	// Entry checks, plus the exception-exit and branch-arming checks
	entry_flags_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		take |=> liveStatus[ST_EXC_ACTIVE] && !liveStatus[ST_USER] && !liveStatus[ST_LVL1_EN]
		&& !liveStatus[ST_LVL2_EN] && !liveStatus[ST_PENDING_SLOT])
		else $error("Entry flags wrong");
	entry_redirect_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		take |=> redirectValid
		&& redirect.pc == s_q.vecBase + ({24'h000000, s_q.causeVec} << VEC_SHIFT))
		else $error("Vector redirect wrong");
	saved_status_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		take |=> s_q.savedStatus[ST_PENDING_SLOT] == $past(commit.inSlot))
		else $error("Saved slot flag wrong");
	double_fault_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		take && liveStatus[ST_EXC_ACTIVE] |=> s_q.causeVec == VEC_MACHINE_CHECK)
		else $error("Double fault not machine check");
	return_addr_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		take && !commit.fault.trap |=> s_q.retAddr == $past(commit.pc))
		else $error("Return address wrong");
	fault_addr_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		take && commit.fault.memAccess |=> s_q.faultAddr == $past(commit.memAddr))
		else $error("Fault address wrong");
	exc_exit_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		doReturn && !take && liveStatus[ST_EXC_ACTIVE] |=> redirect.pc == $past(s_q.retAddr)
		&& liveStatus == $past(s_q.savedStatus))
		else $error("Exception exit wrong");
	arm_branch_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		redirectValid && !liveStatus[ST_EXC_ACTIVE] |-> redirect.armBranch ==
		liveStatus[ST_PENDING_SLOT])
		else $error("Delayed branch not armed");
	user_return_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		commit.valid && commit.fault.return_from_handler && liveStatus[ST_USER] |=> s_q.causeVec ==
		VEC_PRIV_VIOL || s_q.causeVec == VEC_INSN_ERROR)
		else $error("User return not faulted");
	flush_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		take |-> flushPipe ##1 redirectValid)
		else $error("Flush and redirect not paired");
	flush_other_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		commit.valid && commit.fault.other |-> flushPipe)
		else $error("Fault not flushed");
	flush_idle_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		!commit.valid |-> !flushPipe)
		else $error("Flush without commit");
	block_mem_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		commit.valid && commit.fault.memAccess |-> blockExtWrite)
		else $error("Memory fault not blocked");
	block_unmapped_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		commit.valid && commit.fault.extUnmapped |-> blockExtWrite)
		else $error("Unmapped fault not blocked");
	block_flush_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		blockExtWrite |-> flushPipe)
		else $error("Block without flush");
	trap_return_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		take && commit.fault.trap && !commit.fault.extUnmapped && !commit.fault.extDisabled
		&& !commit.fault.memAccess && !commit.fault.return_from_handler && !liveStatus[ST_EXC_ACTIVE]
		|=> s_q.retAddr == $past(commit.nextPc))
		else $error("Trap return address wrong");
	saved_user_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		take |=> s_q.savedStatus[ST_USER] == $past(liveStatus[ST_USER]))
		else $error("Saved user flag wrong");
	saved_enables_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		take |=> s_q.savedStatus[ST_LVL1_EN] == $past(liveStatus[ST_LVL1_EN])
		&& s_q.savedStatus[ST_LVL2_EN] == $past(liveStatus[ST_LVL2_EN]))
		else $error("Saved enables wrong");
	saved_target_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		take && commit.inSlot |=> s_q.savedTarget == $past(commit.pendTarget))
		else $error("Saved target wrong");
	target_kept_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		take && !commit.inSlot && !(apbWr && paddr == OFF_SAVED_TARGET) |=> $stable(s_q.savedTarget))
		else $error("Saved target disturbed");
	cause_mem_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		take && commit.fault.memAccess && !commit.fault.extUnmapped && !commit.fault.extDisabled
		&& !commit.fault.return_from_handler && !liveStatus[ST_EXC_ACTIVE]
		|=> s_q.causeVec == $past(commit.otherVec) && s_q.causeCode == $past(commit.otherCode))
		else $error("Cause code wrong");
	fault_pc_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		take && !commit.fault.memAccess |=> s_q.faultAddr == $past(commit.pc))
		else $error("Fault instruction address wrong");
	scratch_kept_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		take && !(apbWr && paddr == OFF_SCRATCH) |=> $stable(s_q.scratch))
		else $error("Scratch disturbed by entry");
	vec_base_kept_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		take && !(apbWr && paddr == OFF_VEC_BASE) |=> $stable(s_q.vecBase))
		else $error("Vector base disturbed by entry");
	bta_kept_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		take |=> $stable(branchTarget))
		else $error("Branch target disturbed by entry");
	double_code_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		take && liveStatus[ST_EXC_ACTIVE] |=> s_q.causeCode == CODE_DOUBLE_FAULT)
		else $error("Double fault code wrong");
	slot_return_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		take && commit.inSlot && !commit.fault.trap |=> s_q.retAddr == $past(commit.pc))
		else $error("Slot return address wrong");
	disabled_ext_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		take && commit.fault.extDisabled && !commit.fault.extUnmapped
		&& !liveStatus[ST_EXC_ACTIVE] |=> s_q.causeVec == VEC_PRIV_VIOL)
		else $error("Disabled extension vector wrong");
	unmapped_ext_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		take && commit.fault.extUnmapped && !liveStatus[ST_EXC_ACTIVE]
		|=> s_q.causeVec == VEC_INSN_ERROR && s_q.causeCode == CODE_ILLEGAL)
		else $error("Unmapped extension vector wrong");
	trap_priority_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		take && commit.fault.trap && !commit.fault.memAccess && !commit.fault.extUnmapped
		&& !commit.fault.extDisabled && !commit.fault.return_from_handler && !liveStatus[ST_EXC_ACTIVE]
		|=> s_q.causeVec == VEC_TRAP)
		else $error("Trap priority wrong");
	redirect_cause_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		redirectValid |-> $past(flushPipe) || $past(doReturn))
		else $error("Redirect without cause");
	// Exit checks
	kernel_return_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		doReturn && !flushPipe |=> redirectValid)
		else $error("Kernel return not redirected");
	idle_exit_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		doReturn && !flushPipe && !liveStatus[ST_EXC_ACTIVE] && !liveStatus[ST_LVL1_ACTIVE]
		&& !liveStatus[ST_LVL2_ACTIVE]
		|=> redirect.pc == $past(s_q.retAddr) && liveStatus == $past(s_q.savedStatus))
		else $error("Idle exit wrong");
	lvl2_exit_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		doReturn && !flushPipe && !liveStatus[ST_EXC_ACTIVE] && liveStatus[ST_LVL2_ACTIVE]
		|=> redirect.pc == $past(lvl2LinkAddr)
		&& liveStatus == $past(lvl2SavedStatus))
		else $error("Level 2 exit wrong");
	lvl1_exit_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		doReturn && !flushPipe && !liveStatus[ST_EXC_ACTIVE] && !liveStatus[ST_LVL2_ACTIVE]
		&& liveStatus[ST_LVL1_ACTIVE] |=> redirect.pc == $past(lvl1LinkAddr)
		&& liveStatus == $past(lvl1SavedStatus))
		else $error("Level 1 exit wrong");
	exit_target_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		doReturn && !flushPipe && liveStatus[ST_EXC_ACTIVE]
		|=> branchTarget == $past(s_q.savedTarget) && redirect.target == $past(s_q.savedTarget))
		else $error("Exit branch target wrong");
	arm_target_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		redirectValid && redirect.armBranch |-> redirect.target == branchTarget)
		else $error("Armed branch target wrong");
	// Register checks
	scratch_write_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		apbWr && paddr == OFF_SCRATCH |=> s_q.scratch == $past(pwdata))
		else $error("Scratch write lost");
	scratch_read_a: assert property (@(posedge clk) disable iff (!rstSync_q)
		apbRd && paddr == OFF_SCRATCH |=> prdata == $past(s_q.scratch))
		else $error("Scratch read wrong");
endmodule
`default_nettype wire

// File: bench/exen_commit_model.sv
`timescale 1ns/100ps
`default_nettype none
module exen_commit_model
	import exen_pkg::*;
(
	input wire logic clk,
	input wire logic flushPipe,
	input wire logic blockExtWrite,
	output var exen_commit_t commit,
	output logic [31:0] lvl1LinkAddr,
	output logic [31:0] lvl2LinkAddr,
	output logic [31:0] lvl1SavedStatus,
	output logic [31:0] lvl2SavedStatus,
	output logic [31:0] lvl1SavedTarget,
	output logic [31:0] lvl2SavedTarget
);
	logic [1:0] seen;
	assign lvl1LinkAddr = 32'h00001100;
	assign lvl2LinkAddr = 32'h00002200;
	assign lvl1SavedStatus = 32'h00000001;
	assign lvl2SavedStatus = 32'h00000002;
	assign lvl1SavedTarget = 32'h00001180;
	assign lvl2SavedTarget = 32'h00002280;
	initial commit = '0;
	// One commit for one cycle; afterwards every field is scrambled with valid low
	task automatic send(input exen_commit_t c);
		exen_commit_t idle;
		idle = ~c;
		idle.valid = 1'b0;
		commit <= c;
		@(negedge clk);
		seen = {flushPipe, blockExtWrite};
		@(posedge clk);
		commit <= idle;
	endtask
endmodule
`default_nettype wire

// File: bench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import exen_pkg::*;
;
	localparam logic [31:0] VB = 32'h00004000;
	logic clk = 1'b0;
	logic resetN = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata, rd, l1a, l2a, l1s, l2s, l1t, l2t, liveStatus, branchTarget;
	logic pready, pslverr, flushPipe, blockExtWrite, redirectValid;
	exen_commit_t commit;
	exen_commit_t c;
	exen_redirect_t redirect;
	exen_fault_t fl[5];
	logic [7:0] ev[5];
	int numErrors = 0;
	int comparisons = 0;

	always #10 clk = ~clk;

	exen_entry_exit uut (.clk(clk), .reset_n(resetN), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .commit(commit), .lvl1LinkAddr(l1a), .lvl2LinkAddr(l2a),
		.lvl1SavedStatus(l1s), .lvl2SavedStatus(l2s), .lvl1SavedTarget(l1t),
		.lvl2SavedTarget(l2t), .flushPipe(flushPipe), .blockExtWrite(blockExtWrite),
		.redirectValid(redirectValid), .redirect(redirect), .liveStatus(liveStatus),
		.branchTarget(branchTarget));
	exen_commit_model pm (.clk(clk), .flushPipe(flushPipe), .blockExtWrite(blockExtWrite),
		.commit(commit), .lvl1LinkAddr(l1a), .lvl2LinkAddr(l2a), .lvl1SavedStatus(l1s),
		.lvl2SavedStatus(l2s), .lvl1SavedTarget(l1t), .lvl2SavedTarget(l2t));

	function automatic logic [31:0] va(input logic [7:0] v);
		return VB + {21'h000000, v, 3'h0};
	endfunction
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			numErrors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		penable <= 1'b0;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h00000000);
		chk("read", rd, e);
		chk("pslverr", {31'h0, pslverr}, 32'h0);
	endtask
	task automatic fire(input exen_commit_t f, input logic [31:0] p, input logic arm,
		input logic [31:0] t);
		pm.send(f);
		@(negedge clk);
		chk("redirValid", {31'h0, redirectValid}, 32'h1);
		chk("redirPc", redirect.pc, p);
		chk("arm", {31'h0, redirect.armBranch}, {31'h0, arm});
		if (arm) chk("target", redirect.target, t);
		@(posedge clk);
	endtask
	task automatic final_report();
		$display("Comparisons %0d mismatches %0d", comparisons, numErrors);
		if (numErrors == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	initial begin
		#100000;
		numErrors++;
		final_report();
	end

	initial begin
		fl = '{6'b000101, 6'b001100, 6'b011000, 6'b110000, 6'b000001};
		ev = '{VEC_TRAP, 8'h26, VEC_PRIV_VIOL, VEC_INSN_ERROR, 8'h26};
		repeat (20) @(posedge clk);
		resetN <= 1'b1;
		repeat (3) @(posedge clk);
		rdchk(OFF_LIVE_STATUS, RST_STATUS);
		rdchk(OFF_SCRATCH, RST_SCRATCH);
		apb(1'b1, OFF_SCRATCH, 32'ha5a55a5a);
		rdchk(OFF_SCRATCH, 32'ha5a55a5a);
		rdchk(12'h0fc, 32'h00000000);
		$display("Test registers done");
		apb(1'b1, OFF_VEC_BASE, VB);
		apb(1'b1, OFF_LIVE_STATUS, 32'h00000083);
		c = '0;
		c.valid = 1'b1;
		c.pc = 32'h00000100;
		c.memAddr = 32'h00002000;
		c.pendTarget = 32'h00000300;
		c.inSlot = 1'b1;
		c.otherVec = VEC_DTLB_MISS;
		c.otherCode = 8'h01;
		c.param = 8'h05;
		c.fault.memAccess = 1'b1;
		fire(c, va(VEC_DTLB_MISS), 1'b0, 32'h0);
		chk("flushBlock", {30'h0, pm.seen}, 32'h3);
		chk("live", liveStatus, 32'h00000020);
		rdchk(OFF_RET_ADDR, 32'h00000100);
		rdchk(OFF_SAVED_STATUS, 32'h000000c3);
		rdchk(OFF_SAVED_TARGET, 32'h00000300);
		rdchk(OFF_CAUSE, {8'h00, VEC_DTLB_MISS, 8'h01, 8'h05});
		rdchk(OFF_FAULT_ADDR, 32'h00002000);
		rdchk(OFF_SCRATCH, 32'ha5a55a5a);
		$display("Test entry done");
		c = '0;
		c.valid = 1'b1;
		c.fault.return_from_handler = 1'b1;
		fire(c, 32'h00000100, 1'b1, 32'h00000300);
		chk("live", liveStatus, 32'h000000c3);
		chk("bta", branchTarget, 32'h00000300);
		fire(c, va(VEC_PRIV_VIOL), 1'b0, 32'h0);
		c.fault = exen_fault_t'(6'b000001);
		fire(c, va(VEC_MACHINE_CHECK), 1'b0, 32'h0);
		c.fault = exen_fault_t'(6'b000010);
		apb(1'b1, OFF_LIVE_STATUS, 32'h0000000c);
		fire(c, 32'h00002200, 1'b0, 32'h0);
		chk("live", liveStatus, 32'h00000002);
		apb(1'b1, OFF_LIVE_STATUS, 32'h00000004);
		fire(c, 32'h00001100, 1'b0, 32'h0);
		chk("live", liveStatus, 32'h00000001);
		$display("Test exit done");
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, OFF_LIVE_STATUS, 32'h00000000);
			c = '0;
			c.valid = 1'b1;
			c.pc = 32'h00000500;
			c.nextPc = 32'h00000504;
			c.memAddr = 32'h00002000;
			c.otherVec = 8'h26;
			c.fault = fl[i];
			fire(c, va(ev[i]), 1'b0, 32'h0);
			chk("block", {31'h0, pm.seen[0]}, {31'h0, i != 0});
			rdchk(OFF_RET_ADDR, (i == 0) ? 32'h00000504 : 32'h00000500);
		end
		rdchk(OFF_FAULT_ADDR, 32'h00000500);
		apb(1'b1, OFF_LIVE_STATUS, 32'h00000000);
		c.fault = exen_fault_t'(6'b000010);
		fire(c, 32'h00000500, 1'b0, 32'h0);
		chk("live", liveStatus, 32'h00000000);
		chk("bta", branchTarget, 32'h00000300);
		$display("Test priority done");
		final_report();
	end
endmodule
`default_nettype wire
